// ### bench/tm16_top_tb.sv
// ==========================================
// Purpose: Self-checking bench for the 16-bit timer
// Assumes: Avalon slave answers whenever waitrequest drops
// Notes: Pin periods measured rise to rise at falling edges
`timescale 1ns/1ps
`include "tm16_defines.svh"
module tm16_top_tb;
    import tm16_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [3:0] flag_ack = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, pin_a, pin_a_oe, pin_b, pin_b_oe;
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    int p;
    logic [31:0] d;
    // Divide factors for clock select codes 2 to 5
    int dv [4] = '{8, 64, 256, 1024};
    // Columns: mode, field A, compare A, capture, direction, period, flags
    // variable tops kept at 0x0003 or above
    int tbl [12][7] = '{'{4, 1, 3, 0, 1, 8, 2}, '{4, 1, 3, 0, 0, 0, 2},
        '{12, 1, 2, 9, 1, 20, 10}, '{5, 2, 16, 0, 1, 256, 3}, '{6, 2, 16, 0, 1, 512, 3},
        '{7, 2, 16, 0, 1, 1024, 3}, '{14, 2, 4, 9, 1, 10, 11}, '{14, 2, 32, 9, 1, 0, 9},
        '{14, 2, 9, 9, 1, 0, 11}, '{15, 1, 3, 0, 1, 8, 3}, '{5, 1, 16, 0, 1, 0, 3},
        '{14, 3, 4, 9, 1, 10, 11}};
    tm16_top DUT (.mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .flag_ack(flag_ack), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .waveform_output_a(pin_a), .waveform_output_a_oe(pin_a_oe),
        .waveform_output_b(pin_b), .waveform_output_b_oe(pin_b_oe));
    // ==========================================
    // Clock and timeout
    initial begin
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            end_sim();
        end
    end
    // ==========================================
    // Tasks
    task automatic end_sim();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
        output logic [31:0] rdat);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Period between second and third rise of pin A, 0 if none
    task automatic per(output int pr);
        int k, r, p0;
        logic pv;
        k = 0;
        r = 0;
        p0 = 0;
        pv = pin_a;
        while (r < 3 && k < 4000) begin
            @(negedge mclk);
            k++;
            if (pin_a === 1'b1 && pv === 1'b0) begin
                r++;
                if (r == 2) p0 = k;
            end
            pv = pin_a;
        end
        pr = (r == 3) ? k - p0 : 0;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        bus(0, `TM16_ADR_CTRL, 0, d); chk(d, 0);
        bus(0, `TM16_ADR_FLAG, 0, d); chk(d, 0);
        bus(0, 5'h1c, 0, d); chk(d, 0);
        $display("test reset done");
        // Force A clear and B set, only B direction output
        bus(1, `TM16_ADR_CTRL, 32'h70e0, d);
        repeat (3) @(posedge mclk);
        chk(32'({pin_b_oe, pin_b}), 3);
        bus(0, `TM16_ADR_PIN, 0, d); chk(d, 2);
        bus(1, `TM16_ADR_CTRL, 32'h5080, d);
        repeat (3) @(posedge mclk);
        chk(32'({pin_b_oe, pin_b}), 2);
        bus(1, `TM16_ADR_CTRL, 0, d);
        repeat (3) @(posedge mclk);
        chk(32'({pin_b_oe, pin_b}), 0);
        $display("test force done");
        bus(1, `TM16_ADR_CNT, 32'h0000fff0, d);
        bus(1, `TM16_ADR_CTRL, 32'h00000100, d);
        repeat (30) @(posedge mclk);
        bus(1, `TM16_ADR_CTRL, 0, d);
        bus(0, `TM16_ADR_FLAG, 0, d); chk(d & 32'h1, 1);
        bus(0, `TM16_ADR_CNT, 0, d); chk(32'(d < 32'h40), 1);
        flag_ack <= 4'h1;
        @(posedge mclk);
        flag_ack <= 4'h0;
        bus(0, `TM16_ADR_FLAG, 0, d); chk(d & 32'h1, 0);
        bus(1, `TM16_ADR_CTRL, 5, d);
        bus(1, `TM16_ADR_CMPA, 32'habcd, d);
        bus(0, `TM16_ADR_CMPA, 0, d); chk(d, 32'h00cd);
        $display("test normal done");
        // Ten prescaled ticks per select code, phase unknown
        for (int s = 2; s < 6; s++) begin
            bus(1, `TM16_ADR_CTRL, 0, d);
            bus(1, `TM16_ADR_CNT, 0, d);
            bus(1, `TM16_ADR_CTRL, s << 8, d);
            repeat (10 * dv[s - 2]) @(posedge mclk);
            bus(1, `TM16_ADR_CTRL, 0, d);
            bus(0, `TM16_ADR_CNT, 0, d); chk(32'(d >= 9 && d <= 12), 1);
        end
        $display("test prescale done");
        // Dual-slope codes leave the counter frozen
        bus(1, `TM16_ADR_CNT, 32'h0055, d);
        bus(1, `TM16_ADR_CTRL, 32'h0101, d);
        repeat (20) @(posedge mclk);
        bus(0, `TM16_ADR_CNT, 0, d); chk(d, 32'h0055);
        bus(1, `TM16_ADR_CTRL, 32'h0108, d);
        repeat (20) @(posedge mclk);
        bus(0, `TM16_ADR_CNT, 0, d); chk(d, 32'h0055);
        $display("test frozen done");
        for (int i = 0; i < 12; i++) begin
            bus(1, `TM16_ADR_CTRL, 0, d);
            bus(1, `TM16_ADR_CNT, 0, d);
            bus(1, `TM16_ADR_CAPT, tbl[i][3], d);
            bus(1, `TM16_ADR_CMPA, tbl[i][2], d);
            bus(1, `TM16_ADR_FLAG, 32'hf, d);
            bus(1, `TM16_ADR_CTRL, tbl[i][0] | tbl[i][1] << 4 | 32'h100 | tbl[i][4] << 11, d);
            per(p);
            chk(p, tbl[i][5]);
            chk(32'(pin_a_oe), tbl[i][4]);
            bus(0, `TM16_ADR_FLAG, 0, d); chk(d & 32'hb, tbl[i][6]);
            $display("test row %0d done", i);
        end
        end_sim();
    end
endmodule

// ### design/tm16_chan_if.sv
// ==========================================
// Purpose: Link between counter core and one compare channel
// Assumes: Single clock mclk
// Notes: Match is combinational, output state is registered
`timescale 1ns/1ps
interface tm16_chan_if;
    import tm16_pkg::*;
    logic tick;
    logic block;
    tm16_class_t cls;
    logic [15:0] top;
    logic [15:0] cnt;
    logic [15:0] cmp;
    logic [1:0] com;
    logic frc;
    logic wrap;
    logic tgl_ok;
    logic match;
    logic oc;
    modport ctl (output tick, block, cls, top, cnt, cmp, com, frc, wrap, tgl_ok,
        input match, oc);
    modport unit (input tick, block, cls, top, cnt, cmp, com, frc, wrap, tgl_ok,
        output match, oc);
endinterface

// ### design/tm16_channel.sv
// ==========================================
// Purpose: One compare channel with its waveform state
// Assumes: Counter core drives the link each cycle
// Notes: Bottom action wins over a match in the same tick
`timescale 1ns/1ps
`include "tm16_defines.svh"
module tm16_channel (
    input wire logic mclk,
    input wire logic rstn,
    tm16_chan_if.unit ch
);
    import tm16_pkg::*;
    tm16_chan_t q;
    tm16_chan_t d;
    logic fits;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    function automatic logic act(input logic [1:0] com, input logic oc);
        case (com)
            `TM16_COM_TGL: act = ~oc;
            `TM16_COM_CLR: act = 1'b0;
            `TM16_COM_SET: act = 1'b1;
            default: act = oc;
        endcase
    endfunction

    // in fast PWM, no match while compare lies above top
    assign fits = (ch.cls != mc_fast) || (ch.cmp <= ch.top);
    assign ch.match = ch.tick && !ch.block && (ch.cls != mc_idle) && fits
        && (ch.cnt == ch.cmp);

    // Output state update
    always_comb begin
        d = q;
        if (ch.cls inside {mc_normal, mc_ctc}) begin
            // set, clear or toggle on match
            if (ch.frc || ch.match) begin
                d.oc = act(ch.com, q.oc);
            end
        end else if (ch.cls == mc_fast) begin
            // polarity: clear code bottom-set, set code bottom-clear
            unique case (ch.com)
                `TM16_COM_OFF: d.oc = q.oc;
                // toggle only when compare A is top
                `TM16_COM_TGL: d.oc = (ch.tgl_ok && ch.match) ? ~q.oc : q.oc;
                // bottom wins, giving spike or constant level
                `TM16_COM_CLR: d.oc = ch.wrap ? 1'b1 : (ch.match ? 1'b0 : q.oc);
                `TM16_COM_SET: d.oc = ch.wrap ? 1'b0 : (ch.match ? 1'b1 : q.oc);
            endcase
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ch.oc = q.oc;

    a_ctc_toggle: assert property (
        ch.cls == mc_ctc && ch.com == `TM16_COM_TGL && ch.match |=> ch.oc != $past(ch.oc))
        else $error("toggle missed on match");
    a_no_high_cmp: assert property (
        ch.cls == mc_fast && ch.cmp > ch.top |-> !ch.match)
        else $error("match with compare above top");
    c_fast_match: cover property (ch.cls == mc_fast && ch.match);
endmodule

// ### design/tm16_defines.svh
// ==========================================
// Purpose: Constants for the 16-bit timer
// Assumes: Included by bare name
// Notes: Offsets are byte addresses
`ifndef TM16_DEFINES_SVH
`define TM16_DEFINES_SVH
`define TM16_ADR_CTRL 5'h00
`define TM16_ADR_CNT 5'h04
`define TM16_ADR_CMPA 5'h08
`define TM16_ADR_CMPB 5'h0c
`define TM16_ADR_CAPT 5'h10
`define TM16_ADR_FLAG 5'h14
`define TM16_ADR_PIN 5'h18
`define TM16_F_MODE 3:0
`define TM16_F_COMA 5:4
`define TM16_F_COMB 7:6
`define TM16_F_CS 10:8
`define TM16_B_DIRA 11
`define TM16_B_DIRB 12
`define TM16_B_FRCA 13
`define TM16_B_FRCB 14
`define TM16_B_OVF 0
`define TM16_B_CMPA 1
`define TM16_B_CMPB 2
`define TM16_B_CAPT 3
`define TM16_RST_CNT 16'h0000
`define TM16_MAX 16'hffff
`define TM16_TOP8 16'h00ff
`define TM16_TOP9 16'h01ff
`define TM16_TOP10 16'h03ff
`define TM16_WM_NORM 4'h0
`define TM16_WM_CTCA 4'h4
`define TM16_WM_FIX8 4'h5
`define TM16_WM_FIX9 4'h6
`define TM16_WM_FIX10 4'h7
`define TM16_WM_CTCC 4'hc
`define TM16_WM_FCAP 4'he
`define TM16_WM_FCMP 4'hf
`define TM16_COM_OFF 2'h0
`define TM16_COM_TGL 2'h1
`define TM16_COM_CLR 2'h2
`define TM16_COM_SET 2'h3
`define TM16_CS_1 3'h1
`define TM16_CS_8 3'h2
`define TM16_CS_64 3'h3
`define TM16_CS_256 3'h4
`define TM16_CS_1024 3'h5
`define TM16_DIV8 10'h007
`define TM16_DIV64 10'h03f
`define TM16_DIV256 10'h0ff
`define TM16_DIV1024 10'h3ff
`endif

// ### design/tm16_pkg.sv
// ==========================================
// Purpose: Types shared by the timer modules
// Assumes: Nothing
// Notes: All module state is one packed struct
package tm16_pkg;
    typedef enum logic [1:0] {mc_normal, mc_ctc, mc_fast, mc_idle} tm16_class_t;
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] cmp_a;
        logic [15:0] buf_a;
        logic [15:0] cmp_b;
        logic [15:0] buf_b;
        logic [15:0] capt;
        logic [3:0] mode;
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [2:0] cs;
        logic dir_a;
        logic dir_b;
        logic frc_a;
        logic frc_b;
        logic ovf;
        logic flag_a;
        logic flag_b;
        logic flag_c;
        logic block;
        logic wait_r;
        logic [31:0] rdata;
        logic pin_a;
        logic pin_a_oe;
        logic pin_b;
        logic pin_b_oe;
    } tm16_top_t;
    typedef struct packed {
        logic [9:0] count;
        logic tick;
    } tm16_pre_t;
    typedef struct packed {
        logic oc;
    } tm16_chan_t;
endpackage

// ### design/tm16_prescale.sv
// ==========================================
// Purpose: Timer tick divider
// Assumes: Select codes 0, 6 and 7 stop the timer
// Notes: Tick is a one-cycle enable pulse
`timescale 1ns/1ps
`include "tm16_defines.svh"
module tm16_prescale (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [2:0] cs,
    output logic tick
);
    import tm16_pkg::*;
    tm16_pre_t q;
    tm16_pre_t d;

    function automatic logic due(input logic [2:0] sel, input logic [9:0] c);
        case (sel)
            `TM16_CS_1: due = 1'b1;
            `TM16_CS_8: due = ((c & `TM16_DIV8) == `TM16_DIV8);
            `TM16_CS_64: due = ((c & `TM16_DIV64) == `TM16_DIV64);
            `TM16_CS_256: due = ((c & `TM16_DIV256) == `TM16_DIV256);
            `TM16_CS_1024: due = (c == `TM16_DIV1024);
            default: due = 1'b0;
        endcase
    endfunction

    // divide by 1, 8, 64, 256 or 1024
    always_comb begin
        d.count = q.count + 10'h001;
        d.tick = due(cs, q.count);
    end

    // State register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;
endmodule

// ### design/tm16_top.sv
// ==========================================
// Purpose: 16-bit timer, normal, clear-on-compare and fast PWM
// Assumes: Avalon-MM slave, one clock mclk at 10 MHz
// Notes: Dual-slope mode codes freeze the counter
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "tm16_defines.svh"

module tm16_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [3:0] flag_ack,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic waveform_output_a,
    output logic waveform_output_a_oe,
    output logic waveform_output_b,
    output logic waveform_output_b_oe
);
    import tm16_pkg::*;

    // ==========================================
    // Declarations
    tm16_top_t q;
    tm16_top_t d;
    tm16_class_t cls;
    logic [15:0] top;
    logic [15:0] ctrl_img;
    logic [15:0] wv;
    logic [31:0] rd;
    logic [3:0] clr;
    logic [4:0] adr;
    logic pre_tick;
    logic req;
    logic acc;
    logic wr_cnt;
    logic hit;
    logic ovf_set;
    tm16_chan_if ch_a ();
    tm16_chan_if ch_b ();

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // ==========================================
    // Helpers
    function automatic tm16_class_t cls_of(input logic [3:0] m);
        case (m)
            `TM16_WM_NORM: cls_of = mc_normal;
            `TM16_WM_CTCA, `TM16_WM_CTCC: cls_of = mc_ctc;
            `TM16_WM_FIX8, `TM16_WM_FIX9, `TM16_WM_FIX10: cls_of = mc_fast;
            `TM16_WM_FCAP, `TM16_WM_FCMP: cls_of = mc_fast;
            default: cls_of = mc_idle;
        endcase
    endfunction

    function automatic logic [15:0] top_of(input logic [3:0] m,
        input logic [15:0] ca, input logic [15:0] cp);
        case (m)
            `TM16_WM_CTCA, `TM16_WM_FCMP: top_of = ca;
            `TM16_WM_CTCC, `TM16_WM_FCAP: top_of = cp;
            `TM16_WM_FIX8: top_of = `TM16_TOP8;
            `TM16_WM_FIX9: top_of = `TM16_TOP9;
            `TM16_WM_FIX10: top_of = `TM16_TOP10;
            default: top_of = `TM16_MAX;
        endcase
    endfunction

    function automatic logic [15:0] res_mask(input logic [3:0] m);
        case (m)
            `TM16_WM_FIX8: res_mask = `TM16_TOP8;
            `TM16_WM_FIX9: res_mask = `TM16_TOP9;
            `TM16_WM_FIX10: res_mask = `TM16_TOP10;
            default: res_mask = `TM16_MAX;
        endcase
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [15:0] nw, input logic [1:0] be);
        merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    endfunction

    // ==========================================
    // Submodules
    // prescaled tick source
    tm16_prescale u_pre (
        .mclk(mclk),
        .rstn(rstn),
        .cs(q.cs),
        .tick(pre_tick)
    );

    tm16_channel u_ch_a (
        .mclk(mclk),
        .rstn(rstn),
        .ch(ch_a.unit)
    );

    tm16_channel u_ch_b (
        .mclk(mclk),
        .rstn(rstn),
        .ch(ch_b.unit)
    );

    // Decode of mode, top and bus request
    // counting class decoded from the mode field alone
    assign cls = cls_of(q.mode);
    // top from capture, compare A or a fixed constant
    assign top = top_of(q.mode, q.cmp_a, q.capt);
    assign hit = pre_tick && !q.block && (q.cnt == top);
    assign adr = {avs_address[4:2], 2'b00};
    assign req = avs_read || avs_write;
    assign acc = req && !q.wait_r;
    assign wr_cnt = acc && avs_write && (adr == `TM16_ADR_CNT);
    assign ctrl_img = {3'b000, q.dir_b, q.dir_a, q.cs, q.com_b, q.com_a, q.mode};

    // Channel links
    assign ch_a.tick = pre_tick;
    assign ch_a.block = q.block;
    assign ch_a.cls = cls;
    assign ch_a.top = top;
    assign ch_a.cnt = q.cnt;
    assign ch_a.cmp = q.cmp_a;
    assign ch_a.com = q.com_a;
    assign ch_a.frc = q.frc_a;
    assign ch_a.wrap = hit && (cls == mc_fast);
    assign ch_a.tgl_ok = (q.mode == `TM16_WM_FCMP);
    assign ch_b.tick = pre_tick;
    assign ch_b.block = q.block;
    assign ch_b.cls = cls;
    assign ch_b.top = top;
    assign ch_b.cnt = q.cnt;
    assign ch_b.cmp = q.cmp_b;
    assign ch_b.com = q.com_b;
    assign ch_b.frc = q.frc_b;
    assign ch_b.wrap = hit && (cls == mc_fast);
    assign ch_b.tgl_ok = 1'b0;

    // ==========================================
    // Read data selection
    always_comb begin
        rd = 32'h0000_0000;
        case (adr)
            `TM16_ADR_CTRL: rd[15:0] = ctrl_img;
            `TM16_ADR_CNT: rd[15:0] = q.cnt;
            `TM16_ADR_CMPA: rd[15:0] = q.buf_a;
            `TM16_ADR_CMPB: rd[15:0] = q.buf_b;
            `TM16_ADR_CAPT: rd[15:0] = q.capt;
            `TM16_ADR_FLAG: rd[3:0] = {q.flag_c, q.flag_b, q.flag_a, q.ovf};
            `TM16_ADR_PIN: rd[1:0] = {ch_b.oc, ch_a.oc};
            default: rd = 32'h0000_0000;
        endcase
    end

    // Flag clear sources, interrupt taken or write of ones
    // interrupt acknowledge clears its flag
    always_comb begin
        clr = flag_ack;
        if (acc && avs_write && adr == `TM16_ADR_FLAG && avs_byteenable[0]) begin
            clr = flag_ack | avs_writedata[3:0];
        end
    end

    // overflow at top in fast PWM
    assign ovf_set = pre_tick && ((cls inside {mc_normal, mc_ctc} && q.cnt == `TM16_MAX)
        || (cls == mc_fast && hit));

    // ==========================================
    // Next state
    always_comb begin
        d = q;
        wv = 16'h0000;
        d.frc_a = 1'b0;
        d.frc_b = 1'b0;
        // Counter advance on tick only
        if (pre_tick) begin
            d.block = 1'b0;
            unique case (cls)
                mc_normal: d.cnt = q.cnt + 16'h0001;
                mc_ctc: d.cnt = hit ? `TM16_RST_CNT : q.cnt + 16'h0001;
                mc_fast: begin
                    if (hit) begin
                        d.cnt = `TM16_RST_CNT;
                        d.cmp_a = q.buf_a;
                        d.cmp_b = q.buf_b;
                    end else begin
                        d.cnt = q.cnt + 16'h0001;
                    end
                end
                mc_idle: d.cnt = q.cnt;
            endcase
        end
        // Sticky flags, set wins over clear
        d.ovf = ovf_set || (q.ovf && !clr[`TM16_B_OVF]);
        d.flag_a = ch_a.match || (q.flag_a && !clr[`TM16_B_CMPA]);
        d.flag_b = ch_b.match || (q.flag_b && !clr[`TM16_B_CMPB]);
        // capture flag at top in modes 12 and 14
        d.flag_c = (hit && (q.mode == `TM16_WM_CTCC || q.mode == `TM16_WM_FCAP))
            || (q.flag_c && !clr[`TM16_B_CAPT]);
        // Bus handshake, one wait cycle per access
        if (acc) begin
            d.wait_r = 1'b1;
        end else if (req) begin
            d.wait_r = 1'b0;
            d.rdata = rd;
        end
        if (acc && avs_write) begin
            case (adr)
                `TM16_ADR_CTRL: begin
                    wv = merge16(ctrl_img, avs_writedata[15:0], avs_byteenable[1:0]);
                    d.mode = wv[`TM16_F_MODE];
                    d.com_a = wv[`TM16_F_COMA];
                    d.com_b = wv[`TM16_F_COMB];
                    d.cs = wv[`TM16_F_CS];
                    d.dir_a = wv[`TM16_B_DIRA];
                    d.dir_b = wv[`TM16_B_DIRB];
                    d.frc_a = wv[`TM16_B_FRCA];
                    d.frc_b = wv[`TM16_B_FRCB];
                end
                `TM16_ADR_CNT: begin
                    // counter write taken at any time
                    d.cnt = merge16(q.cnt, avs_writedata[15:0], avs_byteenable[1:0]);
                    d.block = 1'b1;
                end
                `TM16_ADR_CMPA: begin
                    wv = merge16(q.buf_a, avs_writedata[15:0], avs_byteenable[1:0]);
                    wv = wv & res_mask(q.mode);
                    d.buf_a = wv;
                    if (cls != mc_fast) begin
                        d.cmp_a = wv;
                    end
                end
                `TM16_ADR_CMPB: begin
                    wv = merge16(q.buf_b, avs_writedata[15:0], avs_byteenable[1:0]);
                    wv = wv & res_mask(q.mode);
                    d.buf_b = wv;
                    if (cls != mc_fast) begin
                        d.cmp_b = wv;
                    end
                end
                `TM16_ADR_CAPT: d.capt = merge16(q.capt, avs_writedata[15:0],
                    avs_byteenable[1:0]);
                default: d.capt = q.capt;
            endcase
        end
        d.pin_a = ch_a.oc && q.dir_a;
        d.pin_a_oe = q.dir_a;
        d.pin_b = ch_b.oc && q.dir_b;
        d.pin_b_oe = q.dir_b;
    end

    // State register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.wait_r <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.wait_r;
    assign waveform_output_a = q.pin_a;
    assign waveform_output_a_oe = q.pin_a_oe;
    assign waveform_output_b = q.pin_b;
    assign waveform_output_b_oe = q.pin_b_oe;

    // ==========================================
    // Checks
    a_norm_wrap: assert property (
        pre_tick && q.mode == `TM16_WM_NORM && q.cnt == `TM16_MAX && !wr_cnt
        |=> q.cnt == `TM16_RST_CNT && q.ovf)
        else $error("normal mode wrap wrong");
    a_ovf_sticky: assert property (
        q.ovf && !clr[0] |=> q.ovf)
        else $error("overflow flag lost");
    a_ack_clears: assert property (
        flag_ack[0] && !ovf_set |=> !q.ovf)
        else $error("overflow not cleared by acknowledge");
    a_cnt_write: assert property (
        wr_cnt && avs_byteenable == 4'hf |=> q.cnt == $past(avs_writedata[15:0]))
        else $error("counter write not taken");
    a_ctc_clear: assert property (
        pre_tick && q.mode == `TM16_WM_CTCC && q.cnt == q.capt && !q.block && !wr_cnt
        |=> q.cnt == `TM16_RST_CNT)
        else $error("clear on capture top missed");
    a_ctc_ovf: assert property (
        pre_tick && cls == mc_ctc && q.cnt == `TM16_MAX |=> q.ovf)
        else $error("overflow missing in clear-on-compare");
    a_fix9_top: assert property (
        pre_tick && q.mode == `TM16_WM_FIX9 && q.cnt == `TM16_TOP9 && !q.block && !wr_cnt
        |=> q.cnt == `TM16_RST_CNT && q.ovf)
        else $error("fixed top clear wrong");
    a_cap_flag: assert property (
        hit && q.mode == `TM16_WM_FCAP |=> q.flag_c && q.ovf)
        else $error("capture flag not set at top");
    a_buf_load: assert property (
        hit && q.mode == `TM16_WM_FCMP |=> q.cmp_a == $past(q.buf_a))
        else $error("buffered compare not loaded at top");
    a_mask_fixed: assert property (
        acc && avs_write && adr == `TM16_ADR_CMPA && q.mode == `TM16_WM_FIX8
        |=> q.buf_a[15:8] == 8'h00)
        else $error("compare write not masked");
    a_pin_gate: assert property (
        !q.dir_a |=> !waveform_output_a && !waveform_output_a_oe)
        else $error("pin driven without direction");
    a_idle_hold: assert property (
        cls == mc_idle && !wr_cnt |=> $stable(q.cnt))
        else $error("counter moved in dual-slope code");
    a_tick_only: assert property (
        !pre_tick && !wr_cnt |=> $stable(q.cnt))
        else $error("counter moved without tick");
    c_norm_wrap: cover property (pre_tick && cls == mc_normal && q.cnt == `TM16_MAX);
    c_ctc_top: cover property (hit && cls == mc_ctc);
    c_fast_top: cover property (hit && cls == mc_fast);
    c_bus_read: cover property (acc && avs_read);
endmodule
